// *** design/lps_ctrl.sv ***
`timescale 1ns/100ps
module lps_ctrl #(
  parameter int PIXELS = lps_pkg::LPS_PIXELS,
  parameter int PIX_W = lps_pkg::LPS_PIX_W,
  parameter logic [lps_pkg::LPS_DIV_W-1:0] HALF_DIV = 16'(lps_pkg::LPS_HALF_DIV)
) (
  // System
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Link
  lps_link_if.ctrl link,
  // User request
  input wire logic start_in,
  input wire logic [lps_pkg::LPS_CNT_W-1:0] period_in,
  // User data
  output logic [PIX_W-1:0] pix_data_out,
  output logic pix_valid_out,
  output logic busy_out
);
  import lps_pkg::*;
  typedef enum logic [1:0] {
    LPS_IDLE = 2'b00,
    LPS_ARM = 2'b01,
    LPS_RUN = 2'b10
  } lps_state_t;
  lps_state_t state_r;
  logic [LPS_DIV_W-1:0] div_r;
  logic lclk_r;
  logic fs_r;
  logic [LPS_CNT_W-1:0] gap_r;
  logic [PIX_W-1:0] data_r;
  logic valid_r;
  logic half_tick;
  logic fall_tick;
  logic rise_tick;
  logic gap_ok;
  assign half_tick = (div_r == HALF_DIV - LPS_DIV_ONE);
  assign rise_tick = half_tick & ~lclk_r;
  assign fall_tick = half_tick & lclk_r;
  // Spacing is never shorter than the least integration time.
  assign gap_ok = (gap_r >= LPS_CNT_W'(LPS_INT_MIN_CYC)) && (gap_r >= period_in);
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_r <= LPS_DIV_ZERO;
      lclk_r <= 1'b0;
    end else begin
      div_r <= half_tick ? LPS_DIV_ZERO : div_r + LPS_DIV_ONE;
      if (half_tick) begin
        lclk_r <= ~lclk_r;
      end
    end
  end
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= LPS_IDLE;
      fs_r <= 1'b0;
      gap_r <= LPS_CNT_ZERO;
    end else begin
      if (rise_tick && gap_r != '1) begin
        gap_r <= gap_r + LPS_CNT_ONE;
      end
      case (state_r)
        LPS_IDLE: begin
          if (start_in && gap_ok && fall_tick) begin
            fs_r <= 1'b1;
            state_r <= LPS_ARM;
          end
        end
        LPS_ARM: begin
          if (fall_tick) begin
            fs_r <= 1'b0;
            gap_r <= LPS_CNT_ONE;
            state_r <= LPS_RUN;
          end
        end
        LPS_RUN: begin
          if (gap_r > LPS_CNT_W'(PIXELS + 1)) begin
            state_r <= LPS_IDLE;
          end
        end
        default: state_r <= LPS_IDLE;
      endcase
    end
  end
  // Pixel level is taken at the falling link edge, half a period after it changed.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_r <= '0;
      valid_r <= 1'b0;
    end else begin
      valid_r <= fall_tick & link.pixel_analog_oe;
      if (fall_tick && link.pixel_analog_oe) begin
        data_r <= link.pixel_analog_out;
      end
    end
  end
  assign link.link_clk = lclk_r;
  assign link.frame_start = fs_r;
  assign pix_data_out = data_r;
  assign pix_valid_out = valid_r;
  assign busy_out = (state_r != LPS_IDLE);
endmodule

// *** design/lps_link_if.sv ***
`timescale 1ns/100ps
interface lps_link_if;
  import lps_pkg::*;
  logic link_clk;
  logic frame_start;
  logic [LPS_PIX_W-1:0] pixel_analog_out;
  logic pixel_analog_oe;
  modport device (input link_clk, input frame_start, output pixel_analog_out,
                  output pixel_analog_oe);
  modport ctrl (output link_clk, output frame_start, input pixel_analog_out,
                input pixel_analog_oe);
endinterface

// *** design/lps_pkg.sv ***
package lps_pkg;
  localparam int LPS_PIXELS = 128;
  localparam int LPS_PIX_W = 8;
  localparam int LPS_CLK_MHZ = 125;
  // Link clock limits in kHz; integration limits in microseconds, the least in tenths of microseconds.
  localparam int LPS_LINK_MIN_KHZ = 5;
  localparam int LPS_LINK_MAX_KHZ = 2000;
  localparam int LPS_INT_MIN_US_X10 = 645;
  localparam int LPS_INT_MAX_US = 100000;
  // Half period of the link clock, in system clocks, for the fastest legal rate.
  localparam int LPS_HALF_DIV = (LPS_CLK_MHZ * 1000 + 2 * LPS_LINK_MAX_KHZ - 1) /
                                (2 * LPS_LINK_MAX_KHZ);
  localparam int LPS_DIV_W = 16;
  localparam logic [LPS_DIV_W-1:0] LPS_DIV_ONE = 16'h0001;
  localparam logic [LPS_DIV_W-1:0] LPS_DIV_ZERO = 16'h0000;
  // Least integration time in link clock periods, rounded up.
  localparam int LPS_INT_MIN_CYC = (LPS_INT_MIN_US_X10 * LPS_LINK_MAX_KHZ + 9999) / 10000;
  localparam int LPS_CNT_W = 32;
  localparam logic [LPS_CNT_W-1:0] LPS_CNT_ONE = 32'h00000001;
  localparam logic [LPS_CNT_W-1:0] LPS_CNT_ZERO = 32'h00000000;
endpackage

// *** design/lps_sensor.sv ***
`timescale 1ns/100ps
module lps_sensor #(
  parameter int PIXELS = lps_pkg::LPS_PIXELS,
  parameter int PIX_W = lps_pkg::LPS_PIX_W
) (
  // System
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Link
  lps_link_if.device link,
  // Light model, one level per pixel
  input wire logic [PIXELS*PIX_W-1:0] pixel_light_in,
  // Observation
  output logic [PIXELS-1:0] stage_out,
  output logic [PIXELS-1:0] integ_reset_out
);
  import lps_pkg::*;
  logic clk_d_r;
  logic [PIXELS-1:0] stage_r;
  logic [PIXELS-1:0] stage_nxt;
  logic [PIXELS-1:0] fall_r;
  logic [PIX_W-1:0] acc_r [PIXELS];
  logic [PIX_W-1:0] out_r;
  logic oe_r;
  logic link_rise;
  logic [PIX_W-1:0] sel_val;
  // The link clock is sampled as a plain input, so edges are found here.
  assign link_rise = link.link_clk & ~clk_d_r;
  assign stage_nxt = {stage_r[PIXELS-2:0], link.frame_start};
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_d_r <= 1'b0;
      stage_r <= '0;
      fall_r <= '0;
    end else begin
      clk_d_r <= link.link_clk;
      fall_r <= '0;
      if (link_rise) begin
        stage_r <= stage_nxt;
        fall_r <= stage_r & ~stage_nxt;
      end
    end
  end
  // Each pixel integrates light until its stage falls; reset restarts the charge.
  genvar g;
  generate
    for (g = 0; g < PIXELS; g++) begin : g_pix
      always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          acc_r[g] <= '0;
        end else if (fall_r[g]) begin
          acc_r[g] <= '0;
        end else if (link_rise && acc_r[g] != '1) begin
          acc_r[g] <= acc_r[g] + {{(PIX_W-1){1'b0}}, |pixel_light_in[g*PIX_W +: PIX_W]};
        end
      end
    end
  endgenerate
  // One-hot stage picks the pixel; zero stages leave the selection at zero.
  always_comb begin
    sel_val = '0;
    for (int i = 0; i < PIXELS; i++) begin
      if (stage_r[i]) begin
        sel_val = sel_val | acc_r[i];
      end
    end
  end
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_r <= '0;
      oe_r <= 1'b0;
    end else begin
      out_r <= sel_val;
      oe_r <= |stage_r;
    end
  end
  assign link.pixel_analog_out = out_r;
  assign link.pixel_analog_oe = oe_r;
  assign stage_out = stage_r;
  assign integ_reset_out = fall_r;
endmodule

// *** test/linear_pixel_scan_sequencer_tb.sv ***
`timescale 1ns/100ps
module linear_pixel_scan_sequencer_tb;
  import lps_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic start_in = 1'b0;
  logic [31:0] period_in = 32'h81;
  logic [31:0] seed = 32'hf013def3;
  logic [LPS_PIXELS*LPS_PIX_W-1:0] light;
  logic [LPS_PIX_W-1:0] pix;
  logic pix_ok;
  logic busy;
  logic [LPS_PIXELS-1:0] stage;
  logic [LPS_PIXELS-1:0] integ;
  int err_total = 0;
  int tests_run = 0;
  int npix = 0;
  int nrst = 0;
  int cyc = 0;
  int last_fs = 0;
  int span = 0;
  logic timed_out = 1'b0;
  lps_link_if link_i();
  lps_sensor lps_sensor_i(.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(link_i),
    .pixel_light_in(light), .stage_out(stage), .integ_reset_out(integ));
  lps_ctrl lps_ctrl_i(.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(link_i),
    .start_in(start_in), .period_in(period_in), .pix_data_out(pix),
    .pix_valid_out(pix_ok), .busy_out(busy));
  lps_link_properties lps_link_properties_i(.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .link_clk(link_i.link_clk), .frame_start(link_i.frame_start),
    .pixel_analog_out(link_i.pixel_analog_out), .pixel_analog_oe(link_i.pixel_analog_oe));
  always #4 ref_clk_in = ~ref_clk_in;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // A lit pixel gains one count per link period from its integrator reset to its read.
  function automatic logic [31:0] level_exp(input logic [7:0] lv, input int span_n);
    if (lv == 8'h00) return 32'h0;
    return (span_n > 256) ? 32'hff : 32'(span_n - 1);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Outputs are looked at on the falling edge, where they have settled.
  always @(negedge ref_clk_in) begin
    cyc++;
    nrst += $countones(integ);
    if (pix_ok) begin
      check(32'(stage == ({{(LPS_PIXELS-1){1'b0}}, 1'b1} << npix)), 32'h1);
      if (span > 0) check(32'(pix), level_exp(light[npix*8+:8], span));
      else check(32'(pix != 8'h00), 32'(light[npix*8+:8] != 8'h00));
      npix++;
    end
    if ($rose(link_i.frame_start)) begin
      if (last_fs > 0) begin
        span = (cyc - last_fs) / (2 * LPS_HALF_DIV);
        check(32'(cyc - last_fs >= period_in * 64), 32'h1);
      end
      last_fs = cyc;
    end
  end
  // Start is held through refusals, so any frame, the first after reset included, waits until the gap is met.
  task automatic frame(input logic [31:0] per);
    int n;
    period_in = per;
    npix = 0;
    nrst = 0;
    start_in = 1'b1;
    for (n = 0; n < 40000 && busy !== 1'b1; n++) @(negedge ref_clk_in);
    start_in = 1'b0;
    for (; n < 40000 && busy === 1'b1; n++) @(negedge ref_clk_in);
    check(32'(n < 40000), 32'h1);
    if (n >= 40000) begin
      timed_out = 1'b1;
    end else begin
      repeat (200) @(negedge ref_clk_in);
      check(npix, 32'h80);
      check(nrst, 32'h80);
      $display("Frame done, period %0d", per);
    end
  endtask
  initial begin
    for (int i = 0; i < LPS_PIXELS; i++) begin
      seed = xs(seed);
      light[i*8+:8] = seed[3] ? seed[7:0] : 8'h00;
    end
    light[7:0] = 8'h00;
    light[1023-:8] = 8'hff;
    repeat (20) @(negedge ref_clk_in);
    rst_in = 1'b0;
    for (int k = 0; k < 3 && !timed_out; k++) begin
      seed = xs(seed);
      frame(k < 2 ? 32'h81 : 32'h81 + seed % 32'hc8);
    end
    wrap_up();
  end
endmodule

// *** test/lps_link_properties.sv ***
`timescale 1ns/100ps
module lps_link_properties (
  // System
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Link
  input wire logic link_clk,
  input wire logic frame_start,
  input wire logic [lps_pkg::LPS_PIX_W-1:0] pixel_analog_out,
  input wire logic pixel_analog_oe
);
  import lps_pkg::*;
  logic [1:0] fs_n_r;
  logic [8:0] oe_n_r;
  logic link_d_r;
  logic link_up;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Link rises are counted in helper logic, as 128 is too long to unroll.
  assign link_up = link_clk & ~link_d_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      link_d_r <= 1'b0;
      fs_n_r <= 2'h0;
      oe_n_r <= 9'h000;
    end else begin
      link_d_r <= link_clk;
      fs_n_r <= !frame_start ? 2'h0 : fs_n_r + 2'(link_up && fs_n_r != 2'h3);
      oe_n_r <= !pixel_analog_oe ? 9'h000 : oe_n_r + 9'(link_up);
    end
  end
  a_start_one_edge: assert property (fs_n_r < 2'h2) else $error("two start edges");
  a_start_at_low: assert property ($changed(frame_start) |-> !link_clk)
    else $error("start moved");
  a_out_after_start: assert property ($rose(link_clk) && frame_start |-> ##[1:3] pixel_analog_oe)
    else $error("no output");
  a_out_needs_start: assert property ($rose(pixel_analog_oe) |-> frame_start)
    else $error("stray output");
  a_out_length: assert property ($fell(pixel_analog_oe) |-> oe_n_r == 9'h080)
    else $error("bad length");
  a_idle_hiz: assert property (!pixel_analog_oe && !frame_start |=> !pixel_analog_oe)
    else $error("not released");
  a_data_on_rise: assert property ($changed(pixel_analog_out) |-> link_clk)
    else $error("data moved");
  a_link_half: assert property ($changed(link_clk) |=> $stable(link_clk)[*8])
    else $error("link too fast");
endmodule
